// file: design/timer16_consts.svh
// Offsets, field positions, reset values and timing counts of the timer.
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH
// ----------------------------------------------------------------------
// Register byte offsets on the AHB-Lite bus.
// ----------------------------------------------------------------------
`define OFS_CTRL      6'h00
`define OFS_COUNT     6'h04
`define OFS_CMP_A     6'h08
`define OFS_CMP_B     6'h0c
`define OFS_CAPT      6'h10
`define OFS_FLAGS     6'h14
`define OFS_FORCE     6'h18
`define OFS_PORT      6'h1c
// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define FLG_OVF       0
`define FLG_CMP_A     1
`define FLG_CMP_B     2
`define FLG_CAPT      3
// ----------------------------------------------------------------------
// Waveform mode codes, clock selects and counter limits.
// ----------------------------------------------------------------------
`define WGM_NORMAL    4'h0
`define WGM_CTC_A     4'h4
`define WGM_CTC_CAPT  4'hc
`define CS_STOP       3'h0
`define CS_DIV1       3'h1
`define CS_DIV8       3'h2
`define CS_DIV64      3'h3
`define CS_DIV256     3'h4
`define CS_DIV1024    3'h5
`define CNT_MAX       16'hffff
`define CNT_BOTTOM    16'h0000
`define LATCH_RST     2'h0
`define PRESC_MAX     10'h3ff
`endif

// file: design/timer16_pkg.sv
// Types shared by the timer design.
package timer16_pkg;
    // Bus phase of the register slave.
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WRITE,
        PH_RDWAIT,
        PH_RDOUT
    } bus_phase_t;

    // Complete state of the timer block.
    typedef struct packed {
        bus_phase_t  phase;
        logic [5:0]  addr;
        logic [3:0]  waveform_mode;
        logic [1:0]  com_a;
        logic [1:0]  com_b;
        logic [2:0]  clk_sel;
        logic [15:0] counter_value;
        logic [15:0] compare_a_value;
        logic [15:0] compare_b_value;
        logic [15:0] capture_value;
        logic [3:0]  flags;
        logic [1:0]  port_data;
        logic [1:0]  output_pin_direction;
        logic [1:0]  compare_output_latch;
        logic [9:0]  presc;
        logic        block_pend;
        logic [2:0]  match_dly;
        logic [31:0] hrdata;
    } timer_state_t;
endpackage

// file: design/timer16_compare_output_ctc.sv
// Sixteen-bit timer with compare-output latches and clear-on-match mode.
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`include "timer16_consts.svh"

module timer16_compare_output_ctc
    import timer16_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             pin_a_out,
    output logic             pin_a_oe,
    output logic             pin_b_out,
    output logic             pin_b_oe
);
    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // True in the modes whose compare actions are set, clear or toggle.
    function automatic logic non_pwm(input logic [3:0] m);
        non_pwm = (m == `WGM_NORMAL) || (m == `WGM_CTC_A) ||
                  (m == `WGM_CTC_CAPT);
    endfunction

    // Applies an output mode action to one latch bit.
    function automatic logic apply_com(input logic [1:0] com,
                                       input logic       q);
        case (com)
            2'h1: apply_com = ~q;    // Toggle.
            2'h2: apply_com = 1'b0;  // Clear.
            2'h3: apply_com = 1'b1;  // Set.
            default: apply_com = q;  // No action.
        endcase
    endfunction

    // Decodes the clock select into a one-cycle timer tick.
    function automatic logic presc_tick(input logic [2:0] sel,
                                        input logic [9:0] p);
        case (sel)
            `CS_DIV1:    presc_tick = 1'b1;
            `CS_DIV8:    presc_tick = (p[2:0] == 3'h7);
            `CS_DIV64:   presc_tick = (p[5:0] == 6'h3f);
            `CS_DIV256:  presc_tick = (p[7:0] == 8'hff);
            `CS_DIV1024: presc_tick = (p == `PRESC_MAX);
            default:     presc_tick = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // State and decoded strobes
    // ------------------------------------------------------------------
    timer_state_t st_reg;   // Registered state of the whole block.
    timer_state_t st_next;  // Next value of the state.
    logic         tick;     // One-cycle timer clock enable.
    logic         ctc;      // Clear-on-match mode selected.
    logic [15:0]  top;      // Top value in clear-on-match mode.
    logic         match_a;  // Compare match of channel A.
    logic         match_b;  // Compare match of channel B.
    logic         top_hit;  // Counter reached top in clear-on-match.
    logic         wr;       // Write data phase active.
    logic         cnt_wr;   // Software writes the counter.
    logic         force_a;  // Force strobe for channel A.
    logic         force_b;  // Force strobe for channel B.
    logic         accept;   // Address phase taken this cycle.
    logic [3:0]   flag_set; // Hardware flag set sources.
    logic [3:0]   flag_clr; // Software flag clears.

    // Timer tick from the free running prescaler.
    assign tick = presc_tick(st_reg.clk_sel, st_reg.presc);

    // Top register choice follows the waveform mode alone.
    assign ctc = (st_reg.waveform_mode == `WGM_CTC_A) ||
                 (st_reg.waveform_mode == `WGM_CTC_CAPT);
    assign top = (st_reg.waveform_mode == `WGM_CTC_CAPT) ?
                 st_reg.capture_value : st_reg.compare_a_value;

    // Full width compares, live against unbuffered registers.
    // A pending counter write suppresses every match.
    assign match_a = tick && !st_reg.block_pend &&
                     (st_reg.counter_value == st_reg.compare_a_value);
    assign match_b = tick && !st_reg.block_pend &&
                     (st_reg.counter_value == st_reg.compare_b_value);
    assign top_hit = tick && !st_reg.block_pend && ctc &&
                     (st_reg.counter_value == top);

    // Write strobes decoded from the data phase.
    assign wr      = (st_reg.phase == PH_WRITE);
    assign cnt_wr  = wr && (st_reg.addr == `OFS_COUNT);
    assign force_a = wr && (st_reg.addr == `OFS_FORCE) && hwdata[0];
    assign force_b = wr && (st_reg.addr == `OFS_FORCE) && hwdata[1];
    assign flag_clr = (wr && (st_reg.addr == `OFS_FLAGS)) ?
                      hwdata[3:0] : 4'h0;

    // Bus answer: one wait state on reads only, always OKAY.
    assign hreadyout = (st_reg.phase != PH_RDWAIT);
    assign hresp     = 1'b0;
    assign accept    = hsel && htrans[1] && hready;
    assign hrdata    = st_reg.hrdata;

    // ------------------------------------------------------------------
    // Hardware flag sources
    // ------------------------------------------------------------------

    // Overflow as the counter passes maximum, unless overwritten.
    // Compare and capture flags come one tick after the match.
    always_comb begin
        flag_set = 4'h0;
        flag_set[`FLG_OVF] = tick && !cnt_wr &&
                             (st_reg.counter_value == `CNT_MAX);
        if (tick) begin
            flag_set[`FLG_CMP_A] = st_reg.match_dly[0];
            flag_set[`FLG_CMP_B] = st_reg.match_dly[1];
            flag_set[`FLG_CAPT]  = st_reg.match_dly[2];
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;

        // Prescaler runs free so every divider stays phase aligned.
        st_next.presc = st_reg.presc + 10'h001;

        // Bus phase sequencing.
        case (st_reg.phase)
            PH_RDWAIT: begin
                st_next.phase = PH_RDOUT;
            end
            PH_IDLE, PH_WRITE, PH_RDOUT: begin
                if (accept) begin
                    st_next.addr  = haddr[5:0];
                    st_next.phase = hwrite ? PH_WRITE : PH_RDWAIT;
                end else begin
                    st_next.phase = PH_IDLE;
                end
            end
            default: begin
                st_next.phase = PH_IDLE;
            end
        endcase

        // Read data is captured in the wait state, after prior writes.
        if (st_reg.phase == PH_RDWAIT) begin
            case (st_reg.addr)
                `OFS_CTRL:  st_next.hrdata = {21'h0, st_reg.clk_sel,
                                st_reg.com_b, st_reg.com_a,
                                st_reg.waveform_mode};
                `OFS_COUNT: st_next.hrdata = {16'h0, st_reg.counter_value};
                `OFS_CMP_A: st_next.hrdata = {16'h0, st_reg.compare_a_value};
                `OFS_CMP_B: st_next.hrdata = {16'h0, st_reg.compare_b_value};
                `OFS_CAPT:  st_next.hrdata = {16'h0, st_reg.capture_value};
                `OFS_FLAGS: st_next.hrdata = {28'h0, st_reg.flags};
                `OFS_PORT:  st_next.hrdata = {26'h0,
                                st_reg.compare_output_latch,
                                st_reg.output_pin_direction,
                                st_reg.port_data};
                default:    st_next.hrdata = 32'h0;
            endcase
        end

        // Register writes; unmapped offsets are ignored.
        if (wr) begin
            case (st_reg.addr)
                `OFS_CTRL: begin
                    // New output modes take effect in the next cycle, without waiting for a match.
                    st_next.waveform_mode = hwdata[3:0];
                    st_next.com_a         = hwdata[5:4];
                    st_next.com_b         = hwdata[7:6];
                    st_next.clk_sel       = hwdata[10:8];
                end
                `OFS_CMP_A: st_next.compare_a_value = hwdata[15:0];
                `OFS_CMP_B: st_next.compare_b_value = hwdata[15:0];
                `OFS_CAPT:  st_next.capture_value   = hwdata[15:0];
                `OFS_PORT: begin
                    st_next.port_data            = hwdata[1:0];
                    st_next.output_pin_direction = hwdata[3:2];
                end
                default: begin
                end
            endcase
        end

        // Counting sequence decided by waveform mode only.
        if (tick) begin
            if (top_hit) begin
                st_next.counter_value = `CNT_BOTTOM;
            end else begin
                st_next.counter_value =
                    st_reg.counter_value + 16'h0001;
            end
            st_next.match_dly = {top_hit &&
                (st_reg.waveform_mode == `WGM_CTC_CAPT), match_b, match_a};
        end

        // Software counter write wins over counting at any time.
        if (cnt_wr) begin
            st_next.counter_value = hwdata[15:0];
            st_next.block_pend    = 1'b1;
        end else if (tick) begin
            st_next.block_pend    = 1'b0;
        end

        // Flags: hardware set wins over a software clear.
        st_next.flags = (st_reg.flags & ~flag_clr) | flag_set;

        // Latch actions in non-PWM modes; PWM codes are reserved here.
        if (non_pwm(st_reg.waveform_mode)) begin
            if (match_a || force_a) begin
                st_next.compare_output_latch[0] =
                    apply_com(st_reg.com_a, st_reg.compare_output_latch[0]);
            end
            if (match_b || force_b) begin
                st_next.compare_output_latch[1] =
                    apply_com(st_reg.com_b, st_reg.compare_output_latch[1]);
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Asynchronous reset loads constants only.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.compare_output_latch <= `LATCH_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------

    // Latch replaces port data when output mode is nonzero.
    // Direction always comes from the port direction bits.
    // No capture path exists, so output mode cannot reach it.
    assign pin_a_out = (st_reg.com_a != 2'h0) ?
                       st_reg.compare_output_latch[0] : st_reg.port_data[0];
    assign pin_b_out = (st_reg.com_b != 2'h0) ?
                       st_reg.compare_output_latch[1] : st_reg.port_data[1];
    assign pin_a_oe  = st_reg.output_pin_direction[0];
    assign pin_b_oe  = st_reg.output_pin_direction[1];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    // Latches are low in the first cycle after reset.
    reset_latch_a: assert property (@(posedge core_clk)
        $fell(sys_rst) |-> st_reg.compare_output_latch == 2'h0)
        else $error("latch not cleared by reset");

    // Pin shows the latch whenever override is on.
    pin_override_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (st_reg.com_a != 2'h0) |-> pin_a_out == st_reg.compare_output_latch[0])
        else $error("pin A not overridden by latch");

    // Direction write reaches the enable one cycle later.
    pin_dir_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (wr && st_reg.addr == `OFS_PORT) |=> pin_b_oe == $past(hwdata[3]))
        else $error("pin B enable not from direction bit");

    // Passing maximum sets overflow on the same tick.
    ovf_set_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (tick && !cnt_wr && st_reg.counter_value == `CNT_MAX) |=>
        (st_reg.flags[`FLG_OVF] && st_reg.counter_value == 16'h0000))
        else $error("overflow not set at wrap");

    // Clear-on-match returns the counter to bottom.
    ctc_clear_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (top_hit && !cnt_wr) |=> st_reg.counter_value == 16'h0000)
        else $error("counter not cleared at top");

    // Compare flag rises only at the tick after its match.
    flag_delay_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (tick && st_reg.match_dly[0]) |=> st_reg.flags[`FLG_CMP_A])
        else $error("compare A flag missing one tick after match");

    // Counter write suppresses matches until the next tick.
    write_block_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (cnt_wr || (st_reg.block_pend && !tick)) |=>
        (!match_a && !match_b && !top_hit))
        else $error("match not blocked after counter write");

    // Toggle mode flips the latch at every match in a non-PWM mode.
    toggle_match_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (match_a && st_reg.com_a == 2'h1 && non_pwm(st_reg.waveform_mode))
        |=> st_reg.compare_output_latch[0] !=
            $past(st_reg.compare_output_latch[0]))
        else $error("latch A did not toggle on match");

    // Force leaves the compare flag alone.
    force_noflag_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (force_a && !(tick && st_reg.match_dly[0]) && flag_clr == 4'h0)
        |=> $stable(st_reg.flags[`FLG_CMP_A]))
        else $error("force changed compare A flag");

    // Writing one clears a flag when no set coincides.
    flag_clear_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (flag_clr[`FLG_OVF] && !flag_set[`FLG_OVF]) |=>
        !st_reg.flags[`FLG_OVF])
        else $error("overflow flag not cleared by write");

    // Pin B shows its latch whenever its override is on.
    pin_override_b_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (st_reg.com_b != 2'h0) |-> pin_b_out == st_reg.compare_output_latch[1])
        else $error("pin B not overridden by latch");

    // Output mode zero leaves the latch alone at a match.
    zero_mode_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (match_a && st_reg.com_a == 2'h0) |=>
        $stable(st_reg.compare_output_latch[0]))
        else $error("latch A changed with output mode zero");

    // Only a software write may take the overflow flag down.
    ovf_hold_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (st_reg.flags[`FLG_OVF] && !flag_clr[`FLG_OVF]) |=>
        st_reg.flags[`FLG_OVF])
        else $error("overflow flag cleared by hardware");

    // Main scenarios.
    ctc_top_c: cover property (@(posedge core_clk) top_hit && ctc);
    wrap_c: cover property (@(posedge core_clk)
        tick && st_reg.counter_value == `CNT_MAX);
    force_c: cover property (@(posedge core_clk) force_a);
    block_c: cover property (@(posedge core_clk)
        st_reg.block_pend && tick);
endmodule

// file: sim/pin_load_model.sv
// Pin load model: an output pin with a weak pull-down.
module pin_load_model
(
    input  wire logic drv_out,
    input  wire logic drv_oe,
    output logic      level
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Pin level
    // ------------------------------------------------------------------
    // The driver reaches the pin only while enabled; else the pull-down.
    assign level = drv_oe ? drv_out : 1'b0;
endmodule

// file: sim/timer16_compare_output_ctc_bench.sv
// Bench for the timer: register bus, counter modes and output pins.
`include "timer16_consts.svh"
module timer16_compare_output_ctc_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        core_clk = 1'b0;   // Clock of 20 MHz.
    logic        sys_rst  = 1'b1;   // Reset, held at start.
    logic        hsel     = 1'b0;   // Bus select.
    logic [31:0] haddr    = 32'h0;  // Bus address.
    logic [1:0]  htrans   = 2'h0;   // Transfer type.
    logic        hwrite   = 1'b0;   // Write strobe.
    logic [2:0]  hsize    = 3'h2;   // Always a word.
    logic [31:0] hwdata   = 32'h0;  // Write data.
    logic        hreadyout;         // Slave ready.
    logic        hresp;             // Slave response.
    logic [31:0] hrdata;            // Read data.
    logic        pin_a_out;         // Pin A value.
    logic        pin_a_oe;          // Pin A enable.
    logic        pin_b_out;         // Pin B value.
    logic        pin_b_oe;          // Pin B enable.
    logic        pa;                // Pin A level.
    logic        pb;                // Pin B level.
    logic [31:0] r;                 // Last read word.
    int          mismatches = 0;    // Failed compares.
    int          checked    = 0;    // All compares.
    int          n;                 // Measured half period.
    logic [1:0]  cm [5] = '{2'h2, 2'h1, 2'h0, 2'h3, 2'h1}; // Modes.
    logic        le [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0}; // Latches.
    int          dv [5] = '{1, 8, 64, 256, 1024};           // Dividers.

    always #25 core_clk = ~core_clk;

    timer16_compare_output_ctc dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
        .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));
    pin_load_model pin_a (.drv_out(pin_a_out), .drv_oe(pin_a_oe),
        .level(pa));
    pin_load_model pin_b (.drv_out(pin_b_out), .drv_oe(pin_b_oe),
        .level(pb));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Counts a compare and reports a mismatch at once.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask

    // One single transfer: address phase, then data phase.
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {26'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // Register write and read.
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    // Polls the flag word until the given bit rises, at most 100 reads.
    task automatic wait_flag(input int b);
        logic [31:0] v;
        int          k;
        k = 0;
        do begin
            rd(`OFS_FLAGS, v);
            k++;
        end while (v[b] !== 1'b1 && k < 100);
        chk(v[b], 1);
    endtask

    // Cycles between two changes of pin A, after a first change.
    task automatic half(output int c);
        logic v;
        int   k;
        k = 0;
        v = pa;
        while (pa === v && k < 5000) begin
            @(posedge core_clk);
            k++;
        end
        v = pa;
        c = 0;
        while (pa === v && c < 5000) begin
            @(posedge core_clk);
            c++;
        end
    endtask

    // Control word from mode, output mode A and clock select.
    function automatic logic [31:0] ctl(input logic [3:0] w,
                                        input logic [1:0] a,
                                        input logic [2:0] c);
        return {21'h0, c, 2'h0, a, w};
    endfunction

    // Prints the verdict and ends the run.
    task automatic test_done();
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    // Tests need about 6000 cycles; a hang is cut off well beyond.
    initial begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        test_done();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        chk({pin_a_out, pin_a_oe, pin_b_out, pin_b_oe}, 0);
        rd(`OFS_PORT, r);
        chk(r, 32'h0);
        rd(6'h20, r);
        chk(r, 32'h0);
        // Preset latch A by a forced set while the pin is an input.
        wr(`OFS_CTRL, ctl(4'h0, 2'h3, 3'h0));
        wr(`OFS_FORCE, 32'h1);
        rd(`OFS_PORT, r);
        chk(r, 32'h10);
        chk(pa, 0);
        wr(`OFS_PORT, 32'h4);
        // Every output mode through the force strobe.
        for (int i = 0; i < 5; i++) begin
            wr(`OFS_CTRL, ctl(4'h0, cm[i], 3'h0));
            wr(`OFS_FORCE, 32'h1);
            rd(`OFS_PORT, r);
            chk(r, 32'h4 | {le[i], 4'h0});
            chk(pa, (cm[i] != 2'h0) ? le[i] : 1'b0);
        end
        // Channel B: preset by force while its pin is still an input.
        wr(`OFS_CTRL, 32'hc0);
        wr(`OFS_FORCE, 32'h2);
        rd(`OFS_PORT, r);
        chk(r, 32'h24);
        chk(pb, 0);
        wr(`OFS_PORT, 32'hc);
        rd(`OFS_PORT, r);
        chk(r, 32'h2c);
        chk({pb, pa, hresp}, 3'h4);
        // A force in a PWM mode leaves the latches alone.
        wr(`OFS_CTRL, ctl(4'h5, 2'h1, 3'h0));
        wr(`OFS_FORCE, 32'h1);
        rd(`OFS_PORT, r);
        chk(r, 32'h2c);
        rd(`OFS_FLAGS, r);
        chk(r, 32'h0);
        // A counter write hides the match at the next tick.
        wr(`OFS_CMP_B, 32'h20);
        wr(`OFS_COUNT, 32'h20);
        wr(`OFS_CTRL, ctl(4'h0, 2'h0, 3'h1));
        repeat (10) @(posedge core_clk);
        rd(`OFS_FLAGS, r);
        chk(r[2], 0);
        wr(`OFS_CTRL, ctl(4'h0, 2'h0, 3'h0));
        wr(`OFS_COUNT, 32'h1e);
        wr(`OFS_FLAGS, 32'hf);
        wr(`OFS_CTRL, ctl(4'h0, 2'h0, 3'h1));
        wait_flag(2);
        // Normal mode wraps and sets the overflow flag.
        wr(`OFS_CTRL, ctl(4'h0, 2'h0, 3'h0));
        wr(`OFS_COUNT, 32'hffc0);
        wr(`OFS_FLAGS, 32'hf);
        wr(`OFS_CTRL, ctl(4'h0, 2'h0, 3'h1));
        wait_flag(0);
        rd(`OFS_COUNT, r);
        chk(r < 32'h80, 1);
        repeat (20) @(posedge core_clk);
        rd(`OFS_FLAGS, r);
        chk(r[0], 1);
        wr(`OFS_FLAGS, 32'h1);
        rd(`OFS_FLAGS, r);
        chk(r[0], 0);
        // Toggle on every match; half period is N times top plus one.
        // The count starts below top, so no wrap is needed first.
        wr(`OFS_CTRL, ctl(4'h4, 2'h0, 3'h0));
        wr(`OFS_COUNT, 32'h0);
        wr(`OFS_CMP_A, 32'h1);
        for (int c = 0; c < 5; c++) begin
            wr(`OFS_CTRL, ctl(4'h4, 2'h1, 3'(c + 1)));
            wr(`OFS_FLAGS, 32'hf);
            half(n);
            chk(n, 2 * dv[c]);
            rd(`OFS_FLAGS, r);
            chk(r[1], 1);
        end
        // Top taken from the capture register.
        wr(`OFS_CTRL, ctl(4'h0, 2'h0, 3'h0));
        wr(`OFS_CAPT, 32'h2);
        wr(`OFS_CMP_A, 32'hffff);
        wr(`OFS_CTRL, ctl(4'hc, 2'h0, 3'h1));
        wr(`OFS_FLAGS, 32'hf);
        wait_flag(3);
        for (int i = 0; i < 4; i++) begin
            rd(`OFS_COUNT, r);
            chk(r <= 32'h2, 1);
        end
        // A top below the count is missed until the wrap.
        wr(`OFS_CTRL, ctl(4'h4, 2'h0, 3'h0));
        wr(`OFS_CMP_A, 32'h5);
        wr(`OFS_COUNT, 32'h100);
        wr(`OFS_CTRL, ctl(4'h4, 2'h0, 3'h1));
        repeat (20) @(posedge core_clk);
        rd(`OFS_COUNT, r);
        chk(r > 32'h100, 1);
        wr(`OFS_CTRL, ctl(4'h4, 2'h0, 3'h0));
        wr(`OFS_COUNT, 32'hfff0);
        wr(`OFS_FLAGS, 32'hf);
        wr(`OFS_CTRL, ctl(4'h4, 2'h0, 3'h1));
        wait_flag(0);
        rd(`OFS_COUNT, r);
        chk(r <= 32'h5, 1);
        test_done();
    end
endmodule
